/* File: cts_pkg.sv */
// Shared constants and types for the cyclic timer and switch control block
package cts_pkg;

  // Register indices on the serial register port
  localparam logic [6:0] TIMER_SETUP_ADDR    = 7'h06;
  localparam logic [6:0] HS_SHUTDOWN_ADDR    = 7'h07;
  localparam logic [15:0] TIMER_SETUP_RESET  = 16'h0000;
  localparam logic [4:0] HS_SHUTDOWN_RESET   = 5'h00;

  // Shutdown register field positions
  localparam int OV_REC_LSB                  = 12;
  localparam int OT_SCOPE_BIT                = 11;

  // Switch source selections
  localparam logic [3:0] SRC_OFF             = 4'h0;
  localparam logic [3:0] SRC_ON              = 4'h1;
  localparam logic [3:0] SRC_FIRST_TIMER     = 4'h2;
  localparam logic [3:0] SRC_SECOND_TIMER    = 4'h3;

  // On-time codes
  localparam logic [2:0] ON_OFF_LOW          = 3'h0;
  localparam logic [2:0] ON_100US            = 3'h1;
  localparam logic [2:0] ON_300US            = 3'h2;
  localparam logic [2:0] ON_1MS              = 3'h3;
  localparam logic [2:0] ON_10MS             = 3'h4;
  localparam logic [2:0] ON_20MS             = 3'h5;

  // Cyclic wake selections
  localparam logic [1:0] WAKE_FIRST          = 2'h1;
  localparam logic [1:0] WAKE_SECOND         = 2'h2;

  // Time base: one tick is 100 us
  localparam int CLK_KHZ                     = 50000;
  localparam int TICK_US                     = 100;
  localparam int TICK_CYCLES                 = CLK_KHZ * TICK_US / 1000;

  // On-times in ticks
  localparam logic [14:0] T_100US            = 15'h0001;
  localparam logic [14:0] T_300US            = 15'h0003;
  localparam logic [14:0] T_1MS              = 15'h000a;
  localparam logic [14:0] T_10MS             = 15'h0064;
  localparam logic [14:0] T_20MS             = 15'h00c8;

  // Periods in ticks
  localparam logic [14:0] T_50MS             = 15'h01f4;
  localparam logic [14:0] T_100MS            = 15'h03e8;
  localparam logic [14:0] T_200MS            = 15'h07d0;
  localparam logic [14:0] T_500MS            = 15'h1388;
  localparam logic [14:0] T_1S               = 15'h2710;
  localparam logic [14:0] T_2S               = 15'h4e20;

  // Timer setup register layout
  typedef struct packed {
    logic [2:0] second_on_time;
    logic       res12;
    logic [2:0] second_period;
    logic [1:0] cyclic_wake_select;
    logic [2:0] first_on_time;
    logic       res3;
    logic [2:0] first_period;
  } cts_timer_setup_t;

  // Register port request
  typedef struct packed {
    logic        wr_en;
    logic        rd_en;
    logic [6:0]  addr;
    logic [15:0] wdata;
  } cts_reg_req_t;

endpackage : cts_pkg

/* File: cts_timer.sv */
// One cyclic timer: on-time window at the start of every period
`timescale 1ns/10ps
`default_nettype none
module cts_timer
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       tick,
  input  wire logic [2:0] on_code,
  input  wire logic [2:0] per_code,
  output logic            active,
  output logic            period_start
);

  logic [14:0] cnt_q;
  logic [14:0] on_ticks;
  logic [14:0] per_ticks;
  logic        running;
  logic        hold_high;
  logic        wrap;

  // On-time decode
  always_comb
  begin
    case (on_code)
      cts_pkg::ON_100US: on_ticks = cts_pkg::T_100US;
      cts_pkg::ON_300US: on_ticks = cts_pkg::T_300US;
      cts_pkg::ON_1MS:   on_ticks = cts_pkg::T_1MS;
      cts_pkg::ON_10MS:  on_ticks = cts_pkg::T_10MS;
      cts_pkg::ON_20MS:  on_ticks = cts_pkg::T_20MS;
      default:           on_ticks = 15'h0000;
    endcase
  end

  // Period decode, same table for both timers
  always_comb
  begin
    case (per_code)
      3'h0:    per_ticks = cts_pkg::T_10MS;
      3'h1:    per_ticks = cts_pkg::T_20MS;
      3'h2:    per_ticks = cts_pkg::T_50MS;
      3'h3:    per_ticks = cts_pkg::T_100MS;
      3'h4:    per_ticks = cts_pkg::T_200MS;
      3'h5:    per_ticks = cts_pkg::T_500MS;
      3'h6:    per_ticks = cts_pkg::T_1S;
      default: per_ticks = cts_pkg::T_2S;
    endcase
  end

  // Running codes start the timer; stop codes hold it
  assign running   = (on_code >= cts_pkg::ON_100US) && (on_code <= cts_pkg::ON_20MS);
  assign hold_high = on_code > cts_pkg::ON_20MS;
  assign wrap      = cnt_q >= (per_ticks - 15'h0001);

  // Position within the period, held at zero while stopped
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= 15'h0000;
    else if (!running)
      cnt_q <= 15'h0000;
    else if (tick)
      cnt_q <= wrap ? 15'h0000 : cnt_q + 15'h0001;
  end

  // Window at period start; stop codes give low or high
  assign active       = hold_high | (running & (cnt_q < on_ticks));
  assign period_start = running & tick & (cnt_q == 15'h0000);

endmodule : cts_timer
`default_nettype wire

/* File: cts_top.sv */
// Cyclic timers, switch drive and shutdown control of four high-side switches
//
// Notes on behaviour
// - On-time codes 001..101 give 0.1 to 20 ms
// - Code 000 stops, output low; 110 stops, high
// - Reserved on-time 111 behaves like 110
// - Second period codes select 10 ms to 2 s
// - First period codes select 10 ms to 2 s
// - Wake select: none, first, second, reserved
// - Bits 12 and 3 ignore writes, read zero
// - Timer register clears on reset and restart
// - Assigned timer starts once running on-time written
// - Restart switch clear also clears timer fields
// - Failures without restart keep timer settings
// - Cyclic wake and cyclic sense run together
// - Overvoltage recovery bit: stay off or restore
// - Overtemp scope: all switches or only affected
// - Source 0010 follows first, 0011 second timer
`timescale 1ns/10ps
`default_nettype none
module cts_top
#(
  parameter int TICK_CYCLES = cts_pkg::TICK_CYCLES
)
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire cts_pkg::cts_reg_req_t reg_req,
  output logic [15:0]              reg_rdata,
  input  wire logic                restart_entry,
  input  wire logic                failure_event,
  input  wire logic [15:0]         high_side_switch_source,
  input  wire logic [3:0]          other_source_drive,
  input  wire logic                switch_supply_overvoltage,
  input  wire logic [3:0]          switch_overtemp,
  output logic [3:0]               high_side_switch,
  output logic                     cyclic_wake_event
);

  cts_pkg::cts_timer_setup_t setup_q;
  cts_pkg::cts_timer_setup_t setup_wr;
  logic [4:0]  shutdown_q;
  logic [15:0] rdata_d;
  logic [15:0] reg_rdata_q;
  logic [31:0] pre_q;
  logic        tick;
  logic [4:0]  sync1_q;
  logic [4:0]  sync2_q;
  logic        ov;
  logic [3:0]  ot;
  logic        ot_any;
  logic [3:0]  ov_hold_q;
  logic [15:0] source_prev_q;
  logic [3:0]  drive_d;
  logic [3:0]  drive_q;
  logic        wake_q;
  logic        first_active;
  logic        second_active;
  logic        first_start;
  logic        second_start;
  logic        wr_timer;
  logic        wr_shutdown;
  logic        timer_sense;

  // Register map
  // timer_setup at index 06:
  //   15:13 second_on_time
  //   12    reserved, reads zero
  //   11:9  second_period
  //   8:7   cyclic_wake_select
  //   6:4   first_on_time
  //   3     reserved, reads zero
  //   2:0   first_period
  // high_side_shutdown_setup at index 07:
  //   15    switch4_overvoltage_recovery
  //   14    switch3_overvoltage_recovery
  //   13    switch2_overvoltage_recovery
  //   12    switch1_overvoltage_recovery
  //   11    overtemp_shutdown_scope
  //   10:0  not kept, read zero
  //
  // Timing
  //   tick is one pulse every TICK_CYCLES clocks, 100 us
  //   an on-time window opens on the edge a running code is written to a stopped timer
  //   the prescaler restarts on every timer_setup write, so the
  //   first window of a new setting is a whole number of ticks
  //   switch outputs lag the timer state by one register
  //   cyclic_wake_event pulses one clock per wake-selected period
  //
  // Hazards
  //   overvoltage and overtemperature inputs pass two flip-flops,
  //   so protection acts three clocks after the pin changes
  //   an overvoltage latch with recovery 0 is released only by a
  //   new source value for that switch
  //   overtemperature shutdown is not latched; it follows the pin

  // Register decode
  assign wr_timer    = reg_req.wr_en && (reg_req.addr == cts_pkg::TIMER_SETUP_ADDR);
  assign wr_shutdown = reg_req.wr_en && (reg_req.addr == cts_pkg::HS_SHUTDOWN_ADDR);

  // Write image with reserved bits forced to zero
  always_comb
  begin
    setup_wr       = reg_req.wdata;
    setup_wr.res12 = 1'b0;
    setup_wr.res3  = 1'b0;
  end

  // Cyclic sensing flag, tied high; no switch setting is decoded
  assign timer_sense = 1'b1;

  // Timer setup register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      setup_q <= cts_pkg::TIMER_SETUP_RESET;
    else if (restart_entry)
      setup_q <= cts_pkg::TIMER_SETUP_RESET;
    else if (wr_timer)
      setup_q <= setup_wr;
  end

  // Shutdown register, recovery and overtemp scope bits kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shutdown_q <= cts_pkg::HS_SHUTDOWN_RESET;
    else if (wr_shutdown)
      shutdown_q <= reg_req.wdata[15:11];
  end

  // Read data mux, unmapped addresses read zero
  always_comb
  begin
    case (reg_req.addr)
      cts_pkg::TIMER_SETUP_ADDR: rdata_d = setup_q;
      cts_pkg::HS_SHUTDOWN_ADDR: rdata_d = {shutdown_q, 11'h000};
      default:                   rdata_d = 16'h0000;
    endcase
  end

  // Read data is captured on a read strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_q <= 16'h0000;
    else if (reg_req.rd_en)
      reg_rdata_q <= rdata_d;
  end

  assign reg_rdata = reg_rdata_q;

  // 100 us time base, restarted by a timer write so windows are whole ticks
  assign tick = pre_q == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= 32'h0000_0000;
    else if (wr_timer || tick)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  // Supply and temperature monitors come from outside, two-stage synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end
    else
    begin
      sync1_q <= {switch_supply_overvoltage, switch_overtemp};
      sync2_q <= sync1_q;
    end
  end

  assign ov     = sync2_q[4];
  assign ot     = sync2_q[3:0];
  assign ot_any = |ot;

  // First timer
  cts_timer u_first
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .tick         (tick),
    .on_code      (setup_q.first_on_time),
    .per_code     (setup_q.first_period),
    .active       (first_active),
    .period_start (first_start)
  );

  // Second timer
  cts_timer u_second
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .tick         (tick),
    .on_code      (setup_q.second_on_time),
    .per_code     (setup_q.second_period),
    .active       (second_active),
    .period_start (second_start)
  );

  // Per-switch source selection and protection
  genvar i;
  generate
    for (i = 0; i < 4; i++)
    begin : g_sw
      logic [3:0] src;
      logic       sel;
      logic       ot_off;
      assign src = high_side_switch_source[4*i +: 4];

      // Source: off, on, either timer, or another source
      assign sel = (src == cts_pkg::SRC_OFF)          ? 1'b0 :
                   (src == cts_pkg::SRC_ON)           ? 1'b1 :
                   (src == cts_pkg::SRC_FIRST_TIMER)  ? first_active :
                   (src == cts_pkg::SRC_SECOND_TIMER) ? second_active :
                   other_source_drive[i];

      // Overtemp shuts all or only the affected switch
      assign ot_off = shutdown_q[cts_pkg::OT_SCOPE_BIT - 11] ? ot[i] : ot_any;

      assign drive_d[i] = sel & ~ov & ~ov_hold_q[i] & ~ot_off;

      // Overvoltage latch: restore after clearing if recovery set, else on a new source value
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          ov_hold_q[i] <= 1'b0;
        else if (ov)
          ov_hold_q[i] <= 1'b1;
        else if (shutdown_q[cts_pkg::OV_REC_LSB - 11 + i])
          ov_hold_q[i] <= 1'b0;
        else if (src != source_prev_q[4*i +: 4])
          ov_hold_q[i] <= 1'b0;
      end
    end
  endgenerate

  // Switch outputs, source history and wake pulse
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      drive_q       <= 4'h0;
      source_prev_q <= 16'h0000;
      wake_q        <= 1'b0;
    end
    else
    begin
      drive_q       <= drive_d;
      source_prev_q <= high_side_switch_source;
      wake_q        <= ((setup_q.cyclic_wake_select == cts_pkg::WAKE_FIRST) & first_start) |
                       ((setup_q.cyclic_wake_select == cts_pkg::WAKE_SECOND) & second_start);
    end
  end

  // A failure without restart does not touch the timer setup
  logic unused_ok;
  assign unused_ok = failure_event & timer_sense;

  assign high_side_switch  = drive_q;
  assign cyclic_wake_event = wake_q;

endmodule : cts_top
`default_nettype wire

/* File: cts_host.sv */
// Host model issuing register accesses on the strobe port
`timescale 1ns/10ps
`default_nettype none
module cts_host
(
  input  wire logic                  clk,
  output var  cts_pkg::cts_reg_req_t reg_req,
  input  wire logic [15:0]           reg_rdata
);
  initial reg_req = '0;
  // Strobe for one edge, then release with inverted address and data
  task automatic access(input logic w, input logic [6:0] a, input logic [15:0] d,
                        output logic [15:0] q);
    @(posedge clk);
    reg_req <= '{w, !w, a, d};
    @(posedge clk);
    reg_req <= '{1'b0, 1'b0, ~a, ~d};
    @(posedge clk);
    #1 q = reg_rdata;
  endtask : access
endmodule : cts_host
`default_nettype wire

/* File: cts_top_sva.sv */
// Port assertions of the cyclic timer and switch block
`timescale 1ns/10ps
`default_nettype none
module cts_top_sva
#(
  parameter int TICK_CYCLES = 5
)
(
  input wire logic                  clk,
  input wire logic                  rst_n,
  input wire cts_pkg::cts_reg_req_t reg_req,
  input wire logic [15:0]           reg_rdata,
  input wire logic                  restart_entry,
  input wire logic                  failure_event,
  input wire logic [15:0]           high_side_switch_source,
  input wire logic [3:0]            other_source_drive,
  input wire logic                  switch_supply_overvoltage,
  input wire logic [3:0]            switch_overtemp,
  input wire logic [3:0]            high_side_switch,
  input wire logic                  cyclic_wake_event
);
  logic scope_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Shadow of the overtemperature scope bit
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      scope_q <= 1'b0;
    else if (reg_req.wr_en && reg_req.addr == 7'h07)
      scope_q <= reg_req.wdata[11];
  // Timer register accesses
  sequence s_tmr_rd;
    reg_req.rd_en && !reg_req.wr_en && !restart_entry && reg_req.addr == 7'h06;
  endsequence
  sequence s_tmr_wr;
    reg_req.wr_en && !restart_entry && reg_req.addr == 7'h06;
  endsequence
  chk_rsvd_read_zero: assert property (s_tmr_rd |=> !reg_rdata[12] && !reg_rdata[3])
    else $error("reserved timer bits read nonzero");
  chk_write_read_back: assert property (s_tmr_wr ##1 (!reg_req.wr_en && !restart_entry) [*2]
    ##1 s_tmr_rd |=> reg_rdata == ($past(reg_req.wdata, 4) & 16'heff7))
    else $error("timer register read back wrong");
  chk_restart_clear: assert property (restart_entry ##1 !reg_req.wr_en ##1 s_tmr_rd
    |=> reg_rdata == 16'h0000) else $error("timer register kept after restart");
  chk_unmapped_zero: assert property (reg_req.rd_en && reg_req.addr != 7'h06
    && reg_req.addr != 7'h07 |=> reg_rdata == 16'h0000) else $error("unmapped read nonzero");
  chk_ov_all_off: assert property (switch_supply_overvoltage [*4]
    |-> high_side_switch == 4'h0) else $error("switch on during overvoltage");
  chk_ot_all_off: assert property ((!scope_q && switch_overtemp != 4'h0) [*4]
    |-> high_side_switch == 4'h0) else $error("switch on during global overtemp");
  chk_off_src_low: assert property ((high_side_switch_source[3:0] == 4'h0) [*2]
    |-> !high_side_switch[0]) else $error("switch one on with source off");
  chk_wake_single: assert property (cyclic_wake_event |=> !cyclic_wake_event [*8])
    else $error("wake event longer than one pulse");
endmodule : cts_top_sva
bind cts_top cts_top_sva #(.TICK_CYCLES(TICK_CYCLES)) i_cts_top_sva (.clk(clk), .rst_n(rst_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .restart_entry(restart_entry),
  .failure_event(failure_event), .high_side_switch_source(high_side_switch_source),
  .other_source_drive(other_source_drive), .switch_supply_overvoltage(switch_supply_overvoltage),
  .switch_overtemp(switch_overtemp), .high_side_switch(high_side_switch),
  .cyclic_wake_event(cyclic_wake_event));
`default_nettype wire

/* File: cyclic_timer_switch_control_tb.sv */
// Self-checking bench for the cyclic timer and switch block
`timescale 1ns/10ps
`default_nettype none
module cyclic_timer_switch_control_tb;
  localparam int TK = 5;
  logic clk = 1'b0, rst_n = 1'b0, restart_entry = 1'b0, failure_event = 1'b0, ov = 1'b0;
  logic [15:0] src = 16'h0000, rdata, q;
  logic [3:0] ot = 4'h0, hs;
  logic wake;
  cts_pkg::cts_reg_req_t req;
  int failures = 0, num_checks = 0, cyc = 0, n1, n2;
  int exp_on[8] = '{0, 1, 3, 10, 100, 200, 400, 400};
  int per1[4] = '{100, 200, 500, 1000};
  cts_host i_cts_host (.clk(clk), .reg_req(req), .reg_rdata(rdata));
  cts_top #(.TICK_CYCLES(TK)) i_cts_top (.clk(clk), .rst_n(rst_n), .reg_req(req),
    .reg_rdata(rdata), .restart_entry(restart_entry), .failure_event(failure_event),
    .high_side_switch_source(src), .other_source_drive(4'h0), .switch_supply_overvoltage(ov),
    .switch_overtemp(ot), .high_side_switch(hs), .cyclic_wake_event(wake));
  always #10 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rw(input logic w, input logic [6:0] a, input logic [15:0] d);
    i_cts_host.access(w, a, d, q);
  endtask : rw
  // Restart a timer and measure the gap between two wake pulses
  task automatic wake_gap(input logic [15:0] cfg, input int ticks);
    int n;
    rw(1, 7'h06, 16'h0000);
    rw(1, 7'h06, cfg);
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk);
      n = 1;
      while (wake !== 1'b1 && n < 25000)
      begin
        @(negedge clk);
        n++;
      end
    end
    chk(16'(n), 16'(ticks * TK));
  endtask : wake_gap
  task automatic print_verdict();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Cuts a hung run short
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 80000)
    begin
      failures++;
      print_verdict();
    end
  end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rw(0, 7'h06, 16'h0);
    chk(q, 16'h0000);
    rw(1, 7'h06, 16'hffff);
    rw(0, 7'h06, 16'h0);
    chk(q, 16'heff7);
    @(posedge clk) failure_event <= 1'b1;
    @(posedge clk) failure_event <= 1'b0;
    rw(0, 7'h06, 16'h0);
    chk(q, 16'heff7);
    @(posedge clk) restart_entry <= 1'b1;
    @(posedge clk) restart_entry <= 1'b0;
    rw(0, 7'h06, 16'h0);
    chk(q, 16'h0000);
    rw(1, 7'h07, 16'hffff);
    rw(0, 7'h07, 16'h0);
    chk(q, 16'hf800);
    rw(0, 7'h05, 16'h0);
    chk(q, 16'h0000);
    @(posedge clk) src <= 16'h0032;
    // Every on-time code on both timers
    for (int c = 0; c < 8; c++)
    begin
      rw(1, 7'h06, 16'h0000);
      rw(1, 7'h06, {c[2:0], 4'h2, 2'h0, c[2:0], 4'h2});
      n1 = 0;
      n2 = 0;
      repeat (2000)
      begin
        @(negedge clk);
        n1 += hs[0];
        n2 += hs[1];
      end
      chk(16'(n1), 16'(exp_on[c] * TK));
      chk(16'(n2), 16'(exp_on[c] * TK));
    end
    for (int p = 0; p < 4; p++)
      wake_gap({7'h00, 2'h1, 3'h1, 1'b0, p[2:0]}, per1[p]);
    wake_gap({3'h1, 4'h4, 2'h2, 7'h00}, 2000);
    // Overtemperature scope, then overvoltage recovery
    @(posedge clk) src <= 16'h1111;
    rw(1, 7'h07, 16'h1000);
    @(posedge clk) ot <= 4'h2;
    repeat (6) @(negedge clk);
    chk({12'h000, hs}, 16'h0000);
    rw(1, 7'h07, 16'h1800);
    repeat (4) @(negedge clk);
    chk({12'h000, hs}, 16'h000d);
    @(posedge clk) ot <= 4'h0;
    repeat (4) @(posedge clk);
    ov <= 1'b1;
    repeat (6) @(posedge clk);
    ov <= 1'b0;
    repeat (6) @(negedge clk);
    chk({12'h000, hs}, 16'h0001);
    print_verdict();
  end
endmodule : cyclic_timer_switch_control_tb
`default_nettype wire
